// *** core/lcd_duty_and_pin_function_select.sv ***
// Port control register with common and segment pin multiplexing
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module lcd_duty_and_pin_function_select (
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  input wire logic [3:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [3:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  input wire logic [3:0] i_common_wave,
  input wire logic [31:0] i_segment_wave,
  input wire logic [31:0] i_port_out,
  input wire logic i_expansion_latch_clock,
  input wire logic i_expansion_shift_clock,
  input wire logic i_expansion_serial_data,
  input wire logic i_expansion_alternation,
  output logic [3:0] o_common,
  output logic [31:0] o_segment_pin,
  output logic [31:0] o_segment_enable,
  output lcd_pin_pkg::duty_type o_duty
);
  import lcd_pin_pkg::*;

  // ==================================================
  // Register state
  logic [7:0] lcd_port_control;
  logic [7:0] next_lcd_port_control;
  logic aw_held, next_aw_held, w_held, next_w_held;
  logic [3:0] aw_addr, next_aw_addr;
  logic [7:0] w_byte, next_w_byte;
  logic w_lane0, next_w_lane0;
  logic bvalid, next_bvalid;
  logic [1:0] bresp, next_bresp;
  logic rvalid, next_rvalid;
  logic [31:0] rdata, next_rdata;
  logic [1:0] rresp, next_rresp;
  logic [31:0] seg_en;
  logic [3:0] com_en;
  logic [3:0] com_value;
  logic [31:0] seg_value;
  duty_type duty;
  logic parallel_common_enable, expansion_select;
  logic [3:0] segment_select;

  assign duty = duty_type'(lcd_port_control[DUTY_HI_POS:DUTY_LO_POS]); // see R02
  assign parallel_common_enable = lcd_port_control[PARALLEL_COMMON_POS];
  assign expansion_select = lcd_port_control[EXPANSION_SELECT_POS];
  assign segment_select = lcd_port_control[SEGMENT_SELECT_MSB:0];

  // ==================================================
  // Group enable per segment code
  function automatic logic [3:0] group_enable(input logic [3:0] code);
    logic [3:0] g;
    g = 4'h0;
    if (code[3]) begin
      g = 4'hF;
    end else begin
      case (code[2:1])
        2'b01: g = 4'b1000;
        2'b10: g = 4'b1100;
        2'b11: g = 4'b1110;
        default: g = 4'b0000;
      endcase
    end
    return g;
  endfunction

  always_comb begin
    logic [3:0] g;
    g = group_enable(segment_select); // see R10, R11
    if (expansion_select) begin
      g = 4'b0000; // see R12
    end
    for (int i = 0; i < 32; i++) begin
      seg_en[i] = g[i / 8];
    end
  end

  // ==================================================
  // Common drive per duty
  always_comb begin
    com_value = 4'h0;
    com_en = 4'h0;
    case (duty)
      DUTY_STATIC: begin
        com_value = {4{i_common_wave[0]}}; // see R05
        com_en = parallel_common_enable ? 4'b1111 : 4'b0001; // see R03, R04
      end
      DUTY_HALF: begin
        if (parallel_common_enable) begin
          // Commons 4 and 3 share one wave, commons 2 and 1 the other
          com_value = {i_common_wave[1], i_common_wave[1],
                       i_common_wave[0], i_common_wave[0]}; // see R07
        end else begin
          com_value = {2'b00, i_common_wave[1:0]};
        end
        com_en = parallel_common_enable ? 4'b1111 : 4'b0011; // see R06
      end
      DUTY_THIRD: begin
        com_value = {1'b0, i_common_wave[2:0]};
        com_en = 4'b0111; // see R08
      end
      DUTY_QUARTER: begin
        com_value = i_common_wave;
        com_en = 4'b1111; // see R02
      end
      default: begin
        com_value = 4'h0;
        com_en = 4'h0;
      end
    endcase
  end

  // ==================================================
  // Segment pin multiplexing
  // Top four pins: latch clock, shift clock, serial data, alternation
  logic [3:0] expansion_value;

  assign expansion_value = {i_expansion_latch_clock, i_expansion_shift_clock,
                            i_expansion_serial_data, i_expansion_alternation}; // see R09, R14

  // A pin not owned by the segment driver follows the port logic, except the top four when expansion is selected
  generate
    for (genvar gi = 0; gi < 32; gi++) begin : g_seg_mux
      if (gi >= 28) begin : g_top
        assign seg_value[gi] = expansion_select ? expansion_value[gi - 28] :
                               (seg_en[gi] ? i_segment_wave[gi] : i_port_out[gi]); // see R15
      end else begin : g_low
        assign seg_value[gi] = seg_en[gi] ? i_segment_wave[gi] : i_port_out[gi]; // see R15
      end
    end
  endgenerate

  // ==================================================
  // Pin output registers
  logic [3:0] next_common;
  logic [31:0] next_segment_pin;
  logic [31:0] next_segment_enable;
  duty_type next_duty;

  // Unused commons are held low so the panel sees no stray wave
  always_comb begin
    next_common = com_value & com_en; // see R04, R06, R08
    next_segment_pin = seg_value;
    next_segment_enable = seg_en;
    next_duty = duty;
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_common <= 4'h0;
      o_segment_pin <= 32'h0000_0000;
      o_segment_enable <= 32'h0000_0000;
      o_duty <= DUTY_STATIC;
    end else begin
      o_common <= next_common;
      o_segment_pin <= next_segment_pin;
      o_segment_enable <= next_segment_enable;
      o_duty <= next_duty;
    end
  end

  // ==================================================
  // Address decode
  // Offsets that answer OKAY; the two status words ignore writes
  function automatic logic addr_known(input logic [3:0] addr);
    return (addr == LCD_PORT_CONTROL_ADDR) || (addr == SEGMENT_ENABLE_ADDR) ||
           (addr == COMMON_ENABLE_ADDR);
  endfunction

  // ==================================================
  // AXI4-Lite slave, write channels
  // Address and data are latched in either order; the answer follows both
  always_comb begin
    next_lcd_port_control = lcd_port_control;
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_byte = w_byte;
    next_w_lane0 = w_lane0;
    next_bvalid = bvalid;
    next_bresp = bresp;
    if (i_awvalid && o_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = i_awaddr;
    end
    if (i_wvalid && o_wready) begin
      next_w_held = 1'b1;
      next_w_byte = i_wdata[7:0];
      next_w_lane0 = i_wstrb[0];
    end
    if (bvalid && i_bready) begin
      next_bvalid = 1'b0;
    end
    if (aw_held && w_held && !bvalid) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = RESP_OKAY;
      if (aw_addr == LCD_PORT_CONTROL_ADDR) begin
        if (w_lane0) begin
          next_lcd_port_control = w_byte; // see R01
        end
      end else if (!addr_known(aw_addr)) begin
        next_bresp = RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      lcd_port_control <= LCD_PORT_CONTROL_RESET; // see R01
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 4'h0;
      w_byte <= 8'h00;
      w_lane0 <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else begin
      lcd_port_control <= next_lcd_port_control;
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_byte <= next_w_byte;
      w_lane0 <= next_w_lane0;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
    end
  end

  // ==================================================
  // AXI4-Lite slave, read channels
  // One read in flight: arready stays low while rvalid waits
  always_comb begin
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (rvalid && i_rready) begin
      next_rvalid = 1'b0;
    end
    if (i_arvalid && o_arready) begin
      next_rvalid = 1'b1;
      next_rresp = RESP_OKAY;
      case (i_araddr)
        LCD_PORT_CONTROL_ADDR: next_rdata = {24'h00_0000, lcd_port_control}; // see R01
        SEGMENT_ENABLE_ADDR: next_rdata = seg_en;
        COMMON_ENABLE_ADDR: next_rdata = {28'h000_0000, com_en};
        default: begin
          next_rdata = 32'h0000_0000;
          next_rresp = RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end else begin
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

  // ==================================================
  // Handshake outputs
  assign o_awready = !aw_held;
  assign o_wready = !w_held;
  assign o_bvalid = bvalid;
  assign o_bresp = bresp;
  assign o_arready = !rvalid;
  assign o_rvalid = rvalid;
  assign o_rdata = rdata;
  assign o_rresp = rresp;
endmodule
`default_nettype wire

// *** core/lcd_pin_pkg.sv ***
// Constants for the LCD duty and pin function select block
// Functional notes
// R01: Eight bit register, read write, resets zero
// R02: Duty field selects static, half, third, quarter
// R03: Parallel bit repeats active commons on unused; in third duty the code ignores it and holds common 4 low
// R04: Static, parallel clear: only common 1 driven
// R05: Static, parallel set: commons 2-4 copy 1
// R06: Half, parallel clear: commons 1,2 driven only
// R07: Half, parallel set: 4 copies 3, 2 copies 1
// R08: Third duty drives commons 1-3, 4 unused
// R09: Expansion bit muxes segment pins 32 to 29
// R10: Expansion off, codes 0000/0001: pins 32-29 ports
// R11: Segment code enables groups of eight segments
// R12: Expansion on: only code 0000, rest ports
// R13: Software leaves expansion bit at reset value
// R14: Expansion pins carry latch, shift, data, alternation
// R15: Port groups released from LCD driver
package lcd_pin_pkg;
  localparam logic [3:0] LCD_PORT_CONTROL_ADDR = 4'h0;
  localparam logic [3:0] SEGMENT_ENABLE_ADDR = 4'h4;
  localparam logic [3:0] COMMON_ENABLE_ADDR = 4'h8;
  localparam logic [7:0] LCD_PORT_CONTROL_RESET = 8'h00;
  localparam int DUTY_HI_POS = 7;
  localparam int DUTY_LO_POS = 6;
  localparam int PARALLEL_COMMON_POS = 5;
  localparam int EXPANSION_SELECT_POS = 4;
  localparam int SEGMENT_SELECT_MSB = 3;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [1:0] {
    DUTY_STATIC = 2'b00,
    DUTY_HALF = 2'b01,
    DUTY_THIRD = 2'b10,
    DUTY_QUARTER = 2'b11
  } duty_type;
endpackage

// *** dv/lcd_duty_and_pin_function_select_tb.sv ***
// Self-checking bench for the LCD duty and pin function select block
`timescale 1ns/1ps
`default_nettype none
module lcd_duty_and_pin_function_select_tb;
  import lcd_pin_pkg::*;
  logic i_core_clk = 0, i_arst_n = 0, i_awvalid = 0, i_wvalid = 0, i_bready = 0, i_arvalid = 0;
  logic i_rready = 0, i_expansion_latch_clock = 0, i_expansion_shift_clock = 0;
  logic i_expansion_serial_data = 0, i_expansion_alternation = 0;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic [1:0] o_bresp, o_rresp, rs;
  logic [3:0] i_awaddr = 0, i_araddr = 0, i_wstrb = 0, i_common_wave = 0, o_common, lit, ec, s;
  logic [3:0] ce;
  logic [31:0] i_wdata = 0, i_segment_wave = 0, i_port_out = 0, o_rdata, o_segment_pin;
  logic [31:0] o_segment_enable, rd, en, ep, d;
  logic [7:0] m;
  duty_type o_duty;
  int failures = 0, n_compared = 0;
  lcd_duty_and_pin_function_select dut (.*);
  lcd_panel_model panel (.i_common(o_common), .i_duty(o_duty), .o_lit_rows(lit));
  initial forever #20 i_core_clk = ~i_core_clk;
  task automatic chk(input logic [31:0] g, e);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("wrong value at %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic give_verdict;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ==========================================
  // Register bus master
  task automatic bus(input bit w, input logic [3:0] a, input logic [31:0] wd, input logic [3:0] ws);
    bit aw, wt, ar, done;
    done = 0;
    if (w) begin
      i_awaddr <= a;
      i_wdata <= wd;
      i_wstrb <= ws;
      i_awvalid <= 1;
      i_wvalid <= 1;
      i_bready <= 1;
    end else begin
      i_araddr <= a;
      i_arvalid <= 1;
      i_rready <= 1;
    end
    for (int n = 0; n < 30 && !done; n++) begin
      @(negedge i_core_clk);
      aw = i_awvalid && o_awready;
      wt = i_wvalid && o_wready;
      ar = i_arvalid && o_arready;
      done = w ? o_bvalid : o_rvalid;
      rs = w ? o_bresp : o_rresp;
      rd = o_rdata;
      @(posedge i_core_clk);
      if (aw) i_awvalid <= 0;
      if (wt) i_wvalid <= 0;
      if (ar) i_arvalid <= 0;
      if (done) i_bready <= 0;
      if (done) i_rready <= 0;
    end
    if (!done) begin
      failures++;
      give_verdict();
    end
    @(posedge i_core_clk);
  endtask
  // ==========================================
  // Expected pins from the register copy m
  task automatic model_pins;
    logic [3:0] c;
    c = i_common_wave;
    case (m[7:6])
      2'h0: ec = {{3{m[5] & c[0]}}, c[0]};
      2'h1: ec = m[5] ? {c[1], c[1], c[0], c[0]} : {2'h0, c[1:0]};
      2'h2: ec = {1'h0, c[2:0]};
      default: ec = c;
    endcase
    en = (m[4] || m[3:1] == 3'h0) ? '0 : m[3] ? '1 : ~(32'hFFFF_FFFF >> (8 * m[2:1]));
    ep = (i_segment_wave & en) | (i_port_out & ~en);
    if (m[4]) ep[31:28] = {i_expansion_latch_clock, i_expansion_shift_clock,
      i_expansion_serial_data, i_expansion_alternation};
  endtask
  initial begin
    void'($urandom(17996));
    repeat (3) @(posedge i_core_clk);
    i_arst_n <= 1;
    m = 8'h00;
    @(posedge i_core_clk);
    bus(0, LCD_PORT_CONTROL_ADDR, '0, '0);
    chk(rd, 32'h0000_0000);
    for (int i = 0; i < 40; i++) begin
      d = $urandom;
      d[7:0] = i < 32 ? {i[4:2], 1'h0, i[3:0]} : {i[2:0], 5'h10};
      s = {3'h7, i % 5 != 0};
      bus(1, LCD_PORT_CONTROL_ADDR, d, s);
      chk(rs, RESP_OKAY);
      if (s[0]) m = d[7:0];
      i_common_wave <= 4'($urandom);
      i_segment_wave <= $urandom;
      i_port_out <= $urandom;
      {i_expansion_latch_clock, i_expansion_shift_clock, i_expansion_serial_data,
        i_expansion_alternation} <= 4'($urandom);
      repeat (2) @(posedge i_core_clk);
      @(negedge i_core_clk);
      model_pins();
      chk(o_common, ec);
      chk(lit, ec & {&m[7:6], m[7], |m[7:6], 1'h1});
      chk(o_segment_enable, en);
      chk(o_segment_pin, ep);
      chk(o_duty, m[7:6]);
      @(posedge i_core_clk);
      bus(0, LCD_PORT_CONTROL_ADDR, '0, '0);
      chk(rd, {24'h00_0000, m});
      chk(rs, RESP_OKAY);
      bus(0, SEGMENT_ENABLE_ADDR, '0, '0);
      chk(rd, en);
      ce = m[7:6] == 2'h3 ? 4'hF : m[7:6] == 2'h2 ? 4'h7 : m[5] ? 4'hF : m[6] ? 4'h3 : 4'h1;
      bus(0, COMMON_ENABLE_ADDR, '0, '0);
      chk(rd, {28'h000_0000, ce});
    end
    $display("sweep test done");
    bus(1, SEGMENT_ENABLE_ADDR, $urandom, 4'hF);
    chk(rs, RESP_OKAY);
    bus(0, LCD_PORT_CONTROL_ADDR, '0, '0);
    chk(rd, {24'h00_0000, m});
    bus(1, LCD_PORT_CONTROL_ADDR, 32'h0000_0000, 4'h1);
    bus(0, LCD_PORT_CONTROL_ADDR, '0, '0);
    chk(rd, 32'h0000_0000);
    bus(1, 4'hC, $urandom, 4'hF);
    chk(rs, RESP_SLVERR);
    bus(0, 4'hC, '0, '0);
    chk(rd, 32'h0000_0000);
    chk(rs, RESP_SLVERR);
    i_arst_n <= 0;
    repeat (3) @(posedge i_core_clk);
    i_arst_n <= 1;
    @(posedge i_core_clk);
    bus(0, LCD_PORT_CONTROL_ADDR, '0, '0);
    chk(rd, 32'h0000_0000);
    $display("bus and reset test done");
    give_verdict();
  end
endmodule
`default_nettype wire

// *** dv/lcd_panel_model.sv ***
// Panel model: only the common electrodes wired for the duty light rows
`timescale 1ns/1ps
`default_nettype none
module lcd_panel_model (
  input wire logic [3:0] i_common,
  input wire lcd_pin_pkg::duty_type i_duty,
  output logic [3:0] o_lit_rows
);
  assign o_lit_rows = i_common & 4'((5'h02 << i_duty) - 5'h01);
endmodule
`default_nettype wire

// *** dv/lcd_pin_props.sv ***
// Port assertions for the LCD duty and pin function select block
`timescale 1ns/1ps
`default_nettype none
module lcd_pin_props
  import lcd_pin_pkg::*;
(
  input wire logic i_core_clk, i_arst_n, i_awvalid, o_awready, i_wvalid, o_wready, o_bvalid,
  input wire logic i_arvalid, o_arready, o_rvalid,
  input wire logic [3:0] i_common_wave, o_common,
  input wire logic [31:0] i_segment_wave, i_port_out, o_segment_pin, o_segment_enable,
  input wire lcd_pin_pkg::duty_type o_duty
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_arst_n);
  logic [3:0] w;
  logic [31:0] s, p;
  always_ff @(posedge i_core_clk) begin
    w <= i_common_wave;
    s <= i_segment_wave;
    p <= i_port_out;
  end
  sequence ok; $past(i_arst_n) && $stable(o_duty); endsequence
  sequence en_ok; $past(i_arst_n) && $stable(o_segment_enable); endsequence
  sequence wr_take; i_awvalid && o_awready && i_wvalid && o_wready; endsequence
  quad_com_a: assert property (ok ##0 o_duty == DUTY_QUARTER |-> o_common == w)
    else $error("quarter commons");
  third_com_a: assert property (ok ##0 o_duty == DUTY_THIRD |-> o_common == {1'h0, w[2:0]})
    else $error("third commons");
  static_com_a: assert property (ok ##0 o_duty == DUTY_STATIC |-> o_common[0] == w[0] &&
    (o_common[3:1] == 3'h0 || o_common[3:1] == {3{w[0]}})) else $error("static commons");
  half_com_a: assert property (ok ##0 o_duty == DUTY_HALF |-> o_common == {2'h0, w[1:0]} ||
    o_common == {w[1], w[1], w[0], w[0]}) else $error("half commons");
  seg_drive_a: assert property (en_ok |-> ((o_segment_pin ^ s) & o_segment_enable) == '0)
    else $error("segment drive");
  port_drive_a: assert property (en_ok |-> ((o_segment_pin ^ p) & ~o_segment_enable
    & 32'h0FFF_FFFF) == '0) else $error("port drive");
  wr_answer_a: assert property (wr_take |-> ##[1:2] o_bvalid) else $error("no write answer");
  rd_answer_a: assert property (i_arvalid && o_arready |-> ##[1:2] o_rvalid)
    else $error("no read answer");
endmodule
bind lcd_duty_and_pin_function_select lcd_pin_props props (.*);
`default_nettype wire
